/* File: src/eeprom_consts.svh */
// named constants for the two-wire eeprom master
`ifndef EEPROM_CONSTS_SVH
`define EEPROM_CONSTS_SVH

// ----------------------------------------
// command codes
// ----------------------------------------
`define CMD_NOOP   4'h0
`define CMD_RECV   4'h1
`define CMD_XMIT   4'h3
`define CMD_STOP   4'h5
`define CMD_RLAST  4'h6
`define CMD_START  4'h9

// ----------------------------------------
// control/status field positions and reset values
// ----------------------------------------
`define BIT_ERROR  7
`define BIT_BUSY   6
`define BIT_RXACK  5
`define BIT_TXACK  4
`define RST_STATUS 8'h30
`define RST_BUFFER 8'h00

// ----------------------------------------
// serial timing
// ----------------------------------------
`define SCK_HZ     78000
`define LINK_HZ    83333333
`define QTR_CYCLES(hz) ((hz) / (4 * `SCK_HZ))
`define ACK_BIT    4'h8
`define QTR_LAST   2'h3
`define LINK_SYNC_INIT 7'h01
`define CORE_SYNC_INIT 3'h3

`endif

/* File: src/eeprom_pkg.sv */
// types shared by the two-wire eeprom master
package eeprom_pkg;

  typedef struct packed {
    logic [3:0] cmd;
    logic [7:0] tx_byte;
  } xfer_req_t;

  typedef struct packed {
    logic [7:0] rx_byte;
    logic       rx_ack_n;
    logic       tx_ack_n;
  } xfer_res_t;

  typedef struct packed {
    logic clk_low;
    logic dat_low;
  } bus_drive_t;

  typedef enum logic [4:0] {
    ENG_IDLE  = 5'h01,
    ENG_START = 5'h02,
    ENG_BITS  = 5'h04,
    ENG_STOP  = 5'h08,
    ENG_DONE  = 5'h10
  } eng_state_t;

endpackage

/* File: src/sync3.sv */
// three-stage level synchroniser, change taken when stages two and three agree
`timescale 1ns/1ns
module sync3 #(
  parameter int                 WIDTH = 1,
  parameter logic [WIDTH-1:0]   INIT  = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // data
  input  wire logic [WIDTH-1:0] din,
  output      logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_dout;

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_dout[i] = (s2[i] == s3[i]) ? s3[i] : dout[i];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1   <= INIT;
      s2   <= INIT;
      s3   <= INIT;
      dout <= INIT;
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= next_dout;
    end
  end
endmodule

/* File: src/tick_gen.sv */
// free-running divider giving one pulse every DIV clocks
`timescale 1ns/1ns
module tick_gen #(
  parameter int DIV = 267
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // pulse out
  output      logic tick
);
  localparam int W = (DIV > 2) ? $clog2(DIV) : 1;

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         next_tick;

  if (DIV < 2) begin : g_bad_div
    $error("tick_gen: DIV must be at least 2");
  end

  always_comb begin
    next_tick = (cnt == W'(DIV - 1));
    next_cnt  = next_tick ? '0 : cnt + W'(1);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule

/* File: src/two_wire_eeprom_master.sv */
// command-driven two-wire eeprom master: sfr side on core_clk, bus engine on link_clk
//
// Behaviour
// - Serial clock and data reach the shared pins only when pin-share select is set.
// - Command 0011 shifts the held byte out to the EEPROM.
// - Busy bit 6 high during an operation; its fall raises the done interrupt.
// - Command 0001 clocks in a byte then drives an acknowledge.
// - Received byte sits in the byte buffer when busy falls.
// - Command 0110 clocks in the last byte with no acknowledge.
// - Command 1001 makes a start condition.
// - Command 0101 makes a stop condition.
// - Command 0000 halts the serial clock; after a start or a transfer it keeps toggling until then or until a stop.
// - Undefined codes do nothing on the bus and set error bit 7.
// - Transmit-ack bit 4, active low, resets 1, 0 once we sent an acknowledge.
// - Serial clock runs at 78kHz in transfers and after a start or transfer until a no-op or stop, held high otherwise.
`timescale 1ns/1ns
`include "eeprom_consts.svh"
module two_wire_eeprom_master #(
  parameter int LINK_HZ = `LINK_HZ
) (
  // clocks and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       link_clk,
  // sfr access
  input  wire logic       ctrl_wr,
  input  wire logic       data_wr,
  input  wire logic [7:0] sfr_wdata,
  output      logic [7:0] serial_eeprom_control_status,
  output      logic [7:0] serial_eeprom_byte_buffer,
  output      logic       serial_done_interrupt,
  // pin sharing
  input  wire logic       eeprom_pin_share_select,
  input  wire logic       gpio_clock_out,
  input  wire logic       gpio_clock_oe,
  input  wire logic       gpio_data_out,
  input  wire logic       gpio_data_oe,
  output      logic [1:0] pin_levels,
  // shared pins
  input  wire logic       shared_clock_pin_i,
  output      logic       shared_clock_pin_o,
  output      logic       shared_clock_pin_oe,
  input  wire logic       shared_data_pin_i,
  output      logic       shared_data_pin_o,
  output      logic       shared_data_pin_oe
);
  localparam int QTR = `QTR_CYCLES(LINK_HZ);

  if (QTR < 2) begin : g_bad_rate
    $error("two_wire_eeprom_master: LINK_HZ too low for the serial clock");
  end

  function automatic logic cmd_valid(input logic [3:0] c);
    return c inside {`CMD_NOOP, `CMD_RECV, `CMD_XMIT, `CMD_STOP, `CMD_RLAST, `CMD_START};
  endfunction

  // ----------------------------------------
  // core domain
  // ----------------------------------------
  eeprom_pkg::xfer_req_t req;
  eeprom_pkg::xfer_req_t next_req;
  eeprom_pkg::xfer_res_t res;
  logic       busy;
  logic       error;
  logic       rx_ack_n;
  logic       tx_ack_n;
  logic       req_tgl;
  logic       ack_prev;
  logic [7:0] buffer;
  logic       next_busy;
  logic       next_error;
  logic       next_rx_ack_n;
  logic       next_tx_ack_n;
  logic       next_req_tgl;
  logic       next_irq;
  logic [7:0] next_buffer;
  logic [2:0] core_sync;
  logic       ack_seen;
  // toggled by the link engine on completion; declared here as the core synchroniser reads it
  logic       ack_tgl;

  sync3 #(.WIDTH(3), .INIT(`CORE_SYNC_INIT)) u_core_sync (
    .clk   (core_clk),
    .rst_n (rst_n),
    .din   ({ack_tgl, shared_clock_pin_i, shared_data_pin_i}),
    .dout  (core_sync)
  );

  assign ack_seen   = core_sync[2] != ack_prev;
  assign pin_levels = core_sync[1:0];

  always_comb begin
    next_busy     = busy;
    next_error    = error;
    next_rx_ack_n = rx_ack_n;
    next_tx_ack_n = tx_ack_n;
    next_req      = req;
    next_req_tgl  = req_tgl;
    next_buffer   = buffer;
    next_irq      = 1'b0;
    // writes during an operation are dropped so the captured byte survives
    if (data_wr && !busy) begin
      next_buffer = sfr_wdata;
    end
    if (ctrl_wr && !busy) begin
      if (cmd_valid(sfr_wdata[3:0])) begin
        next_error   = 1'b0;
        next_busy    = 1'b1;
        next_req     = '{cmd: sfr_wdata[3:0], tx_byte: buffer};
        next_req_tgl = ~req_tgl;
      end else begin
        next_error   = 1'b1;
      end
    end
    if (busy && ack_seen) begin
      next_busy = 1'b0;
      next_irq  = 1'b1;
      if (req.cmd == `CMD_XMIT) begin
        next_rx_ack_n = res.rx_ack_n;
      end
      if (req.cmd inside {`CMD_RECV, `CMD_RLAST}) begin
        next_buffer   = res.rx_byte;
        next_tx_ack_n = res.tx_ack_n;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy                         <= 1'b0;
      error                        <= 1'(`RST_STATUS >> `BIT_ERROR);
      rx_ack_n                     <= 1'b1;
      tx_ack_n                     <= 1'b1;
      req                          <= '0;
      req_tgl                      <= 1'b0;
      ack_prev                     <= 1'b0;
      buffer                       <= `RST_BUFFER;
      serial_done_interrupt        <= 1'b0;
      serial_eeprom_control_status <= `RST_STATUS;
      serial_eeprom_byte_buffer    <= `RST_BUFFER;
    end else begin
      busy                         <= next_busy;
      error                        <= next_error;
      rx_ack_n                     <= next_rx_ack_n;
      tx_ack_n                     <= next_tx_ack_n;
      req                          <= next_req;
      req_tgl                      <= next_req_tgl;
      ack_prev                     <= core_sync[2];
      buffer                       <= next_buffer;
      serial_done_interrupt        <= next_irq;
      serial_eeprom_control_status <= {next_error, next_busy, next_rx_ack_n, next_tx_ack_n, next_req.cmd};
      serial_eeprom_byte_buffer    <= next_buffer;
    end
  end

  // ----------------------------------------
  // link domain
  // ----------------------------------------
  eeprom_pkg::eng_state_t state;
  eeprom_pkg::eng_state_t next_state;
  eeprom_pkg::bus_drive_t drv;
  eeprom_pkg::bus_drive_t next_drv;
  eeprom_pkg::xfer_res_t  next_res;
  logic [6:0] link_sync;
  logic       tick;
  logic       run;
  logic       next_run;
  logic       tgl_seen;
  logic       next_tgl_seen;
  logic       next_ack_tgl;
  logic [1:0] qtr;
  logic [1:0] next_qtr;
  logic [3:0] bitn;
  logic [3:0] next_bitn;
  logic [3:0] cmd;
  logic [3:0] next_cmd;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic       sel_s;
  logic       sda_s;
  logic       new_req;

  // request data is held stable by the core while busy, so only the toggle is synchronised
  sync3 #(.WIDTH(7), .INIT(`LINK_SYNC_INIT)) u_link_sync (
    .clk   (link_clk),
    .rst_n (rst_n),
    .din   ({req_tgl, eeprom_pin_share_select, gpio_clock_out, gpio_clock_oe,
             gpio_data_out, gpio_data_oe, shared_data_pin_i}),
    .dout  (link_sync)
  );

  tick_gen #(.DIV(QTR)) u_tick (
    .clk   (link_clk),
    .rst_n (rst_n),
    .tick  (tick)
  );

  assign sel_s   = link_sync[5];
  assign sda_s   = link_sync[0];
  assign new_req = link_sync[6] != tgl_seen;

  always_comb begin
    next_state    = state;
    next_drv      = drv;
    next_res      = res;
    next_run      = run;
    next_tgl_seen = tgl_seen;
    next_ack_tgl  = ack_tgl;
    next_qtr      = qtr;
    next_bitn     = bitn;
    next_cmd      = cmd;
    next_shreg    = shreg;
    unique case (state)
      eeprom_pkg::ENG_IDLE: begin
        if (new_req) begin
          next_tgl_seen = link_sync[6];
          next_cmd      = req.cmd;
          next_shreg    = req.tx_byte;
          next_qtr      = 2'h0;
          next_bitn     = 4'h0;
          unique case (req.cmd)
            `CMD_START: next_state = eeprom_pkg::ENG_START;
            `CMD_STOP:  next_state = eeprom_pkg::ENG_STOP;
            `CMD_NOOP: begin
              next_run         = 1'b0;
              next_drv.clk_low = 1'b0;
              next_state       = eeprom_pkg::ENG_DONE;
            end
            default:    next_state = eeprom_pkg::ENG_BITS;
          endcase
        end else if (run && tick) begin
          // clock keeps running until a no-op or stop, data line left alone
          next_qtr         = qtr + 2'h1;
          next_drv.clk_low = ~next_qtr[1];
        end
      end
      eeprom_pkg::ENG_START: begin
        if (tick) begin
          next_qtr = qtr + 2'h1;
          unique case (qtr)
            2'h0: next_drv = '{clk_low: 1'b1, dat_low: 1'b0};
            2'h1: next_drv.clk_low = 1'b0;
            2'h2: next_drv.dat_low = 1'b1;
            default: begin
              next_run   = 1'b1;
              next_state = eeprom_pkg::ENG_DONE;
            end
          endcase
        end
      end
      eeprom_pkg::ENG_STOP: begin
        if (tick) begin
          next_qtr = qtr + 2'h1;
          unique case (qtr)
            2'h0: next_drv = '{clk_low: 1'b1, dat_low: 1'b1};
            2'h1: next_drv.clk_low = 1'b0;
            2'h2: next_drv.dat_low = 1'b0;
            default: begin
              // bus released: clock stays high until the next start or transfer
              next_run   = 1'b0;
              next_state = eeprom_pkg::ENG_DONE;
            end
          endcase
        end
      end
      eeprom_pkg::ENG_BITS: begin
        if (tick) begin
          next_qtr = qtr + 2'h1;
          unique case (qtr)
            2'h0: next_drv.clk_low = 1'b1;
            2'h1: begin
              if (bitn == `ACK_BIT) begin
                next_drv.dat_low = (cmd == `CMD_RECV);
              end else begin
                next_drv.dat_low = (cmd == `CMD_XMIT) & ~shreg[7];
              end
            end
            2'h2: next_drv.clk_low = 1'b0;
            default: begin
              if (bitn == `ACK_BIT) begin
                if (cmd == `CMD_XMIT) begin
                  next_res.rx_ack_n = sda_s;
                end else begin
                  next_res.rx_byte  = shreg;
                  next_res.tx_ack_n = (cmd != `CMD_RECV);
                end
                next_run   = 1'b1;
                next_state = eeprom_pkg::ENG_DONE;
              end else begin
                next_shreg = {shreg[6:0], sda_s};
                next_bitn  = bitn + 4'h1;
              end
            end
          endcase
        end
      end
      eeprom_pkg::ENG_DONE: begin
        next_ack_tgl = ~ack_tgl;
        next_qtr     = `QTR_LAST;
        next_state   = eeprom_pkg::ENG_IDLE;
      end
      default: next_state = eeprom_pkg::ENG_IDLE;
    endcase
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      state               <= eeprom_pkg::ENG_IDLE;
      drv                 <= '0;
      res                 <= '{rx_byte: `RST_BUFFER, rx_ack_n: 1'b1, tx_ack_n: 1'b1};
      run                 <= 1'b0;
      tgl_seen            <= 1'b0;
      ack_tgl             <= 1'b0;
      qtr                 <= 2'h0;
      bitn                <= 4'h0;
      cmd                 <= `CMD_NOOP;
      shreg               <= 8'h00;
      shared_clock_pin_o  <= 1'b0;
      shared_clock_pin_oe <= 1'b0;
      shared_data_pin_o   <= 1'b0;
      shared_data_pin_oe  <= 1'b0;
    end else begin
      state               <= next_state;
      drv                 <= next_drv;
      res                 <= next_res;
      run                 <= next_run;
      tgl_seen            <= next_tgl_seen;
      ack_tgl             <= next_ack_tgl;
      qtr                 <= next_qtr;
      bitn                <= next_bitn;
      cmd                 <= next_cmd;
      shreg               <= next_shreg;
      // open drain when shared: only ever pull low
      shared_clock_pin_o  <= sel_s ? 1'b0 : link_sync[4];
      shared_clock_pin_oe <= sel_s ? next_drv.clk_low : link_sync[3];
      shared_data_pin_o   <= sel_s ? 1'b0 : link_sync[2];
      shared_data_pin_oe  <= sel_s ? next_drv.dat_low : link_sync[1];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  busy_on_cmd_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrl_wr && !busy && sfr_wdata[3:0] == `CMD_XMIT |=> serial_eeprom_control_status[`BIT_BUSY])
    else $error("busy did not rise on transmit");
  irq_on_fall_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(serial_eeprom_control_status[`BIT_BUSY]) |-> serial_done_interrupt ##1 !serial_done_interrupt)
    else $error("interrupt missing on busy fall");
  error_on_bad_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrl_wr && !busy && !cmd_valid(sfr_wdata[3:0]) |=>
      serial_eeprom_control_status[`BIT_ERROR] && !serial_eeprom_control_status[`BIT_BUSY])
    else $error("illegal command not flagged");
  rx_byte_ready_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    busy && ack_seen && req.cmd inside {`CMD_RECV, `CMD_RLAST} |=>
      serial_eeprom_byte_buffer == $past(res.rx_byte) && !serial_eeprom_control_status[`BIT_BUSY])
    else $error("received byte not in buffer at busy fall");
  start_cond_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    state == eeprom_pkg::ENG_START && $rose(drv.dat_low) |-> !drv.clk_low && $past(!drv.clk_low))
    else $error("start not made with clock high");
  stop_cond_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    state == eeprom_pkg::ENG_STOP && $fell(drv.dat_low) |-> !drv.clk_low && $past(!drv.clk_low))
    else $error("stop not made with clock high");
  ack_drive_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    state == eeprom_pkg::ENG_BITS && bitn == `ACK_BIT && qtr == 2'h2 && tick |-> drv.dat_low == (cmd == `CMD_RECV))
    else $error("acknowledge drive wrong on ninth clock");
  noop_halt_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    state == eeprom_pkg::ENG_IDLE && new_req && req.cmd == `CMD_NOOP |=> !run [*2])
    else $error("no-op did not halt the clock");
  clk_idle_high_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    state == eeprom_pkg::ENG_IDLE && !run |-> !drv.clk_low)
    else $error("serial clock not high between transfers");
  pin_release_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    sel_s && $stable(sel_s) |=> shared_clock_pin_oe == drv.clk_low && shared_data_pin_oe == drv.dat_low &&
      !shared_clock_pin_o && !shared_data_pin_o)
    else $error("shared pins not following the engine");

  xmit_seen_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    busy && ack_seen && req.cmd == `CMD_XMIT);
  recv_seen_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    busy && ack_seen && req.cmd == `CMD_RECV);
  stop_seen_c: cover property (@(posedge link_clk) disable iff (!rst_n)
    state == eeprom_pkg::ENG_STOP ##1 state == eeprom_pkg::ENG_DONE);
endmodule

/* File: test/eeprom_model.sv */
// behavioural serial eeprom hanging on the two shared pins
`timescale 1ns/1ns
module eeprom_model (
  // bus lines
  input  wire logic       scl,
  input  wire logic       sda,
  output      logic       sda_low,
  // scenario control: mode 0 idle, 1 master writes, 2 master reads
  input  wire logic       arm,
  input  wire logic [1:0] mode,
  input  wire logic       ack_en,
  input  wire logic [7:0] rd_byte,
  // observations
  output      logic [7:0] wr_byte,
  output      logic       ack_bit,
  output      int         rises,
  output      int         starts,
  output      int         stops,
  output      time        period
);
  int         bitn;
  logic [7:0] shift;
  time        last;

  initial begin
    sda_low = 1'b0;
    rises   = 0;
    starts  = 0;
    stops   = 0;
    bitn    = 9;
    last    = 0;
  end

  always @(posedge arm) bitn <= 0;

  // ----------------------------------------
  // drive while clock is low, sample on its rise
  // ----------------------------------------
  always @(negedge scl) begin
    if (mode == 2'h2 && bitn < 8)
      sda_low <= ~rd_byte[7 - bitn];
    else if (mode == 2'h1 && bitn == 8)
      sda_low <= ack_en;
    else
      sda_low <= 1'b0;
  end

  always @(posedge scl) begin
    rises <= rises + 1;
    last  <= $time;
    bitn  <= bitn + 1;
    if (bitn < 8)
      shift <= {shift[6:0], sda};
    if (bitn == 7 && mode == 2'h1)
      wr_byte <= {shift[6:0], sda};
    if (bitn == 8) begin
      ack_bit <= sda;
      period  <= $time - last;
    end
  end

  // data edges while the clock stands high frame the bus
  always @(negedge sda) if (scl === 1'b1) starts <= starts + 1;
  always @(posedge sda) if (scl === 1'b1) stops <= stops + 1;
endmodule

/* File: test/testbench.sv */
// self-checking bench for the two-wire eeprom master
`timescale 1ns/1ns
`include "eeprom_consts.svh"
module testbench;
  // qtr of 4 link cycles at 12 ns, four quarters a bit
  localparam int PER = 4 * (1248000 / 312000) * 12;
  logic       core_clk, link_clk, rst_n, ctrl_wr, data_wr, sel, irq, seen_irq;
  logic       clk_o, clk_oe, dat_o, dat_oe, sda_low, arm, ack_en, ack_bit;
  logic       exp_rx, exp_tx, exp_err;
  logic [7:0] sfr_wdata, status, buffer, rd_byte, wr_byte, exp_buf, d;
  logic [3:0] gp, exp_cmd;
  logic [1:0] pin_levels, mode, lv;
  int         err_total, compares, rises, starts, stops, n0, seed;
  time        period;
  // open-drain lines with pull-ups
  wire        scl = (clk_oe === 1'b1) ? clk_o : 1'b1;
  wire        sda = (sda_low === 1'b1) ? 1'b0 : ((dat_oe === 1'b1) ? dat_o : 1'b1);

  two_wire_eeprom_master #(.LINK_HZ(1248000)) two_wire_eeprom_master_inst (
    .core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk), .ctrl_wr(ctrl_wr), .data_wr(data_wr),
    .sfr_wdata(sfr_wdata), .serial_eeprom_control_status(status), .serial_eeprom_byte_buffer(buffer),
    .serial_done_interrupt(irq), .eeprom_pin_share_select(sel), .gpio_clock_out(gp[0]),
    .gpio_clock_oe(gp[1]), .gpio_data_out(gp[2]), .gpio_data_oe(gp[3]), .pin_levels(pin_levels),
    .shared_clock_pin_i(scl), .shared_clock_pin_o(clk_o), .shared_clock_pin_oe(clk_oe),
    .shared_data_pin_i(sda), .shared_data_pin_o(dat_o), .shared_data_pin_oe(dat_oe));

  eeprom_model eeprom_model_inst (
    .scl(scl), .sda(sda), .sda_low(sda_low), .arm(arm), .mode(mode), .ack_en(ack_en),
    .rd_byte(rd_byte), .wr_byte(wr_byte), .ack_bit(ack_bit), .rises(rises), .starts(starts),
    .stops(stops), .period(period));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    link_clk = 1'b0;
    #3;
    forever #6 link_clk = ~link_clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic sfr(input logic is_ctrl, input logic [7:0] v);
    @(negedge core_clk);
    sfr_wdata = v;
    ctrl_wr   = is_ctrl;
    data_wr   = ~is_ctrl;
    @(negedge core_clk);
    ctrl_wr   = 1'b0;
    data_wr   = 1'b0;
  endtask

  // poke writes the buffer while busy, which must be dropped
  task automatic run_cmd(input logic [3:0] c, input logic [1:0] m, input logic poke);
    int   n;
    logic busy_seen;
    busy_seen = 1'b0;
    mode      = m;
    arm       = 1'b1;
    sfr(1'b1, {4'h0, c});
    arm = 1'b0;
    for (n = 0; n < 3000 && irq !== 1'b1; n++) begin
      @(negedge core_clk);
      busy_seen = busy_seen | (status[6] === 1'b1);
      data_wr   = poke && n == 4;
      sfr_wdata = ~exp_buf;
    end
    if (n == 3000) begin
      err_total++;
      stop_test();
    end
    check({7'h0, busy_seen}, 8'h01);
    check({7'h0, status[6]}, 8'h00);
    exp_cmd = c;
    exp_err = 1'b0;
    @(negedge core_clk);
    check(status, {exp_err, 1'b0, exp_rx, exp_tx, exp_cmd});
    check(buffer, exp_buf);
  endtask

  task automatic idle_check;
    n0 = rises;
    repeat (300) @(negedge core_clk);
    check(8'(rises - n0), 8'h00);
    check({7'h0, scl}, 8'h01);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n     = 1'b0;
    ctrl_wr   = 1'b0;
    data_wr   = 1'b0;
    sfr_wdata = 8'h00;
    sel       = 1'b0;
    gp        = 4'h0;
    arm       = 1'b0;
    mode      = 2'h0;
    ack_en    = 1'b1;
    rd_byte   = 8'h00;
    err_total = 0;
    compares  = 0;
    exp_rx    = 1'b1;
    exp_tx    = 1'b1;
    exp_err   = 1'b0;
    exp_buf   = 8'h00;
    exp_cmd   = 4'h0;
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    seed  = $urandom(2);
    check(status, 8'h30);
    check(buffer, 8'h00);
    repeat (6) begin
      gp = 4'($urandom);
      lv = {gp[1] ? gp[0] : 1'b1, gp[3] ? gp[2] : 1'b1};
      repeat (20) @(negedge core_clk);
      check({6'h0, scl, sda}, {6'h0, lv});
      check({6'h0, pin_levels}, {6'h0, lv});
    end
    sel = 1'b1;
    repeat (20) @(negedge core_clk);
    n0 = starts;
    run_cmd(`CMD_START, 2'h0, 1'b0);
    check(8'(starts - n0), 8'h01);
    for (n0 = 0; n0 < 400 && scl !== 1'b0; n0++) @(negedge core_clk);
    check({7'h0, scl}, 8'h00);
    if (n0 == 400)
      stop_test();
    run_cmd(`CMD_NOOP, 2'h0, 1'b0);
    idle_check();
    for (int i = 0; i < 2; i++) begin
      d       = 8'($urandom);
      ack_en  = (i == 0) ? 1'b1 : 1'b0;
      exp_buf = d;
      exp_rx  = ~ack_en;
      sfr(1'b0, d);
      run_cmd(`CMD_XMIT, 2'h1, 1'b1);
      check(wr_byte, d);
      check(8'(period), 8'(PER));
      run_cmd(`CMD_NOOP, 2'h0, 1'b0);
    end
    for (int i = 0; i < 2; i++) begin
      rd_byte = 8'($urandom);
      exp_buf = rd_byte;
      exp_tx  = (i == 1) ? 1'b1 : 1'b0;
      run_cmd((i == 0) ? `CMD_RECV : `CMD_RLAST, 2'h2, 1'b0);
      check({7'h0, ack_bit}, {7'h0, exp_tx});
      run_cmd(`CMD_NOOP, 2'h0, 1'b0);
    end
    n0 = stops;
    run_cmd(`CMD_STOP, 2'h0, 1'b0);
    check(8'(stops - n0), 8'h01);
    idle_check();
    for (int c = 0; c < 16; c++) begin
      if (c inside {0, 1, 3, 5, 6, 9})
        continue;
      n0 = rises;
      sfr(1'b1, 8'(c));
      exp_err  = 1'b1;
      seen_irq = 1'b0;
      repeat (8) begin
        @(negedge core_clk);
        seen_irq = seen_irq | (irq !== 1'b0);
      end
      check({7'h0, seen_irq}, 8'h00);
      check(status, {exp_err, 1'b0, exp_rx, exp_tx, exp_cmd});
      check(8'(rises - n0), 8'h00);
    end
    run_cmd(`CMD_NOOP, 2'h0, 1'b0);
    stop_test();
  end
endmodule
